//--- hw/gnc_poll_responder.sv
// Purpose: non-controller poll responder with service request and transfer gating
// Assumes: addressing states and controller role arrive from protocol logic on ref_clk
// Notes:   bus pins are three-stage synchronised; open-collector lines use enables
// Notes:   addressing and data phases live outside; this block only gates them
//
// What this block does
// - never drive addressing as non-controller
// - stall transfer until addressed for role
// - controller transfer reuses existing talker/listener setup
// - request as controller, no prior setup: refuse, report error 170
// - status bit 6 asserts service request
// - hold request until polled or cleared
// - other status bits stored as written
// - serial poll sends last status byte
// - configured responder drives one line
// - configure change sets sticky event bit
// - configure byte readable at index 7
// - automatic mode uses mask plus need flag
// - only five low configure bits decoded
// - bit 4 set leaves response unconfigured
// - bit 3 chooses need-service polarity
// - bits 2..0 select data line linearly
// - manual mode drives pattern of index 2
// - reading event status clears it
// - events latched, request level live
`timescale 1ns/100ps
module gnc_poll_responder
    import gnc_pkg::*;
(
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    // register port
    input  wire logic [ADDR_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0]  reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [DATA_W-1:0]  reg_rdata,
    // bus pins
    input  wire logic               bus_atn,
    input  wire logic               bus_eoi,
    input  wire logic               bus_srq_in,
    input  wire logic [7:0]         bus_dio_in,
    output logic      [7:0]         bus_dio_out,
    output logic      [7:0]         bus_dio_oe,
    output logic                    bus_srq_out,
    output logic                    bus_srq_oe,
    output logic                    bus_addr_cmd_oe,
    // protocol state from the interface logic
    input  wire logic               active_controller,
    input  wire logic               talker_addressed,
    input  wire logic               listener_addressed,
    input  wire logic               serial_poll_active_state,
    input  wire logic               ppc_received,
    input  wire logic               tl_configured,
    input  wire logic               xfer_done,
    // transfer engine handshake
    output logic                    xfer_start,
    output logic                    xfer_dir_send,
    output logic                    xfer_send_addr
);
    gnc_bus_in_t     pin_raw;
    gnc_bus_in_t     sync_a;
    gnc_bus_in_t     sync_b;
    gnc_bus_in_t     sync_c;
    gnc_bus_in_t     pins;
    gnc_bus_req_t    req;
    logic [3:0]      idx;
    logic [7:0]      spoll_byte;
    logic [7:0]      pp_pattern;
    logic [4:0]      pp_mask;
    logic            auto_mode;
    logic            need_service;
    logic            rsv_pending;
    logic            serial_poll_active_state_q;
    logic            ppc_q;
    logic [15:0]     int_status;
    logic [15:0]     next_int_status;
    logic            identify;
    logic            identify_q;
    logic [7:0]      pp_drive;
    logic [7:0]      pp_oe;
    logic            poll_done;
    gnc_xfer_state_t xf_state;
    logic            xf_dir;
    logic            xf_addr;
    logic [7:0]      xf_error;
    logic            xf_req;
    logic            role_ready;

    assign pin_raw = '{atn: bus_atn, eoi: bus_eoi, srq: bus_srq_in, dio: bus_dio_in};
    assign req     = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign idx     = req.addr[5:2];

    // one-hot line select of a configure byte, gated by its unconfigure bit
    function automatic logic [7:0] pp_line(input logic [4:0] cfg);
        logic [7:0] sel;
        sel = 8'h00;
        // line 0 is the first data line, 7 the eighth
        sel[cfg[PPC_LINE_LSB +: 3]] = 1'b1;
        return cfg[PPC_UNCFG_BIT] ? 8'h00 : sel;
    endfunction : pp_line

    // strobe aimed at one register index; every write decode and the status read-clear go through here, the read mux uses a case
    function automatic logic hit(input logic strobe, input logic [3:0] at, input logic [3:0] want);
        return strobe && (at == want);
    endfunction : hit

    // pins are asynchronous; reset clears every stage so no false edge follows
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_c <= '0;
        end else begin
            sync_a <= pin_raw;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // a change is accepted only once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pins <= '0;
        end else if (sync_b == sync_c) begin
            pins <= sync_c;
        end
    end

    // both pins must have passed the filter before Identify counts
    assign identify = pins.atn & pins.eoi;

    // serial poll status byte and request latch
    // bit 6 stays in the byte as written; the live request is rsv_pending
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            spoll_byte <= RST_BYTE;
        end else if (hit(req.wr, idx, IDX_SPOLL_BYTE)) begin
            spoll_byte <= req.wdata[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            serial_poll_active_state_q <= 1'b0;
        end else begin
            serial_poll_active_state_q <= serial_poll_active_state;
        end
    end

    // a poll ends on the falling edge of the poll state
    assign poll_done = serial_poll_active_state_q & ~serial_poll_active_state;

    // a fresh write wins over a poll ending in the same cycle
    // a poll clears the request only, never the stored byte
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rsv_pending <= 1'b0;
        end else if (hit(req.wr, idx, IDX_SPOLL_BYTE)) begin
            rsv_pending <= req.wdata[SPB_RSV_BIT];
        end else if (poll_done) begin
            rsv_pending <= 1'b0;
        end
    end

    // open-collector: drive low-active wire only while requesting
    assign bus_srq_out = 1'b1;
    assign bus_srq_oe  = rsv_pending;

    // parallel poll setup
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pp_pattern <= RST_BYTE;
        end else if (hit(req.wr, idx, IDX_PP_PATTERN)) begin
            pp_pattern <= req.wdata[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pp_mask <= RST_PP_MASK;
        end else if (hit(req.wr, idx, IDX_PP_MASK)) begin
            // upper configure bits are dropped here, never decoded
            pp_mask <= req.wdata[PPC_MEANING_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            auto_mode    <= 1'b0;
            need_service <= 1'b0;
        end else if (hit(req.wr, idx, IDX_CTRL)) begin
            // mode and need flag change together, so no answer mixes both
            auto_mode    <= req.wdata[CTRL_AUTO_BIT];
            need_service <= req.wdata[CTRL_NEED_BIT];
        end
    end

    // response pattern; polarity bit gives the level of need-service
    // the other level drives a zero, which the wired line reads as false
    // manual mode trusts software: every set pattern bit is driven
    always_comb begin
        if (auto_mode) begin
            pp_oe    = pp_line(pp_mask);
            pp_drive = (need_service == pp_mask[PPC_SENSE_BIT]) ? pp_oe : 8'h00;
        end else begin
            pp_oe    = pp_pattern;
            pp_drive = pp_pattern;
        end
    end

    // data lines driven while Identify holds or while serial polled as talker; released the next clock
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            identify_q  <= 1'b0;
            bus_dio_out <= 8'h00;
            bus_dio_oe  <= 8'h00;
        end else begin
            identify_q <= identify;
            // an Identify wins over a serial poll; a controller never answers it
            if (identify && !active_controller) begin
                bus_dio_out <= pp_drive;
                bus_dio_oe  <= pp_oe;
            end else if (serial_poll_active_state && talker_addressed) begin
                // bit 6 of the poll byte is the stored bit 6 ORed with the live request
                bus_dio_out <= spoll_byte | {1'b0, rsv_pending, 6'h00};
                bus_dio_oe  <= 8'hFF;
            end else begin
                bus_dio_out <= 8'h00;
                bus_dio_oe  <= 8'h00;
            end
        end
    end

    // sticky events; a new event wins over a read-clear
    // events are edges, so a level held for many cycles counts once
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ppc_q <= 1'b0;
        end else begin
            ppc_q <= ppc_received;
        end
    end

    always_comb begin
        next_int_status = int_status;
        if (hit(req.rd, idx, IDX_INT_STATUS)) begin
            next_int_status = RST_INT_STATUS;
        end
        if (ppc_received && !ppc_q) begin
            next_int_status[IS_PPC_BIT] = 1'b1;
        end
        if (poll_done) begin
            next_int_status[IS_SERIAL_POLL_ACTIVE_STATE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            int_status <= RST_INT_STATUS;
        end else begin
            int_status <= next_int_status;
        end
    end

    // transfer gating
    assign xf_req     = hit(req.wr, idx, IDX_XFER) && req.wdata[XF_GO_BIT];
    assign role_ready = xf_dir ? talker_addressed : listener_addressed;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            xf_state <= XF_IDLE;
            xf_dir   <= 1'b0;
            xf_addr  <= 1'b0;
            xf_error <= ERR_NONE;
        end else begin
            case (xf_state)
                XF_IDLE: begin
                    if (xf_req) begin
                        xf_dir   <= req.wdata[XF_DIR_BIT];
                        // a non-controller drops the addressing request at once
                        xf_addr  <= req.wdata[XF_ADDR_BIT] & active_controller;
                        // an earlier refusal code is cleared by each new request
                        xf_error <= ERR_NONE;
                        if (active_controller && !req.wdata[XF_ADDR_BIT] && !tl_configured) begin
                            // refused: stay idle, code left for software
                            xf_error <= ERR_NOT_ALLOWED;
                        end else if (active_controller) begin
                            xf_state <= XF_RUN;
                        end else begin
                            xf_state <= XF_WAIT;
                        end
                    end
                end
                XF_WAIT: begin
                    // made controller while waiting: the existing setup is reused
                    if (active_controller) begin
                        xf_state <= XF_RUN;
                    end else if (role_ready) begin
                        xf_state <= XF_RUN;
                    end
                end
                XF_RUN: begin
                    // the outside engine says when the data phase is over
                    if (xfer_done) begin
                        xf_state <= XF_IDLE;
                    end
                end
                default: begin
                    xf_state <= XF_IDLE;
                end
            endcase
        end
    end

    assign xfer_start      = (xf_state == XF_RUN);
    assign xfer_dir_send   = xf_dir;
    assign xfer_send_addr  = xf_addr & active_controller;
    assign bus_addr_cmd_oe = (xf_state == XF_RUN) & xf_addr & active_controller;

    // register reads, one cycle later
    // idle cycles read zero so a stale word is never taken for fresh
    // status bit 1 is the live request line, not a latched event
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (req.rd) begin
            case (idx)
                IDX_SPOLL_BYTE: reg_rdata <= {24'h0, spoll_byte};
                IDX_PP_PATTERN: reg_rdata <= {24'h0, pp_pattern};
                IDX_INT_STATUS: reg_rdata <= {16'h0, int_status[15:2],
                                              pins.srq, int_status[0]};
                IDX_CFG_BYTE:   reg_rdata <= {24'h0, pins.dio};
                IDX_CTRL:       reg_rdata <= {30'h0, need_service, auto_mode};
                IDX_XFER_STAT:  reg_rdata <= {22'h0, xf_state, xf_error};
                default:        reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule : gnc_poll_responder

//--- include/gnc_pkg.sv
// Purpose: shared constants and types for the bus non-controller poll responder
// Assumes: one clock, synchronous active-high reset
// Notes:   register indices are word indices; byte address is four times the index
package gnc_pkg;
    localparam int          ADDR_W           = 6;
    localparam int          DATA_W           = 32;
    // register indices
    localparam logic [3:0]  IDX_SPOLL_BYTE   = 4'h1;
    localparam logic [3:0]  IDX_PP_PATTERN   = 4'h2;
    localparam logic [3:0]  IDX_INT_STATUS   = 4'h4;
    localparam logic [3:0]  IDX_PP_MASK      = 4'h5;
    localparam logic [3:0]  IDX_CFG_BYTE     = 4'h7;
    localparam logic [3:0]  IDX_CTRL         = 4'h8;
    localparam logic [3:0]  IDX_XFER         = 4'h9;
    localparam logic [3:0]  IDX_XFER_STAT    = 4'hA;
    // serial poll byte fields
    localparam int          SPB_RSV_BIT      = 6;
    // parallel poll configure byte fields
    localparam int          PPC_UNCFG_BIT    = 4;
    localparam int          PPC_SENSE_BIT    = 3;
    localparam int          PPC_LINE_LSB     = 0;
    localparam int          PPC_MEANING_W    = 5;
    // interrupt status bits
    localparam int          IS_PPC_BIT       = 14;
    localparam int          IS_SERIAL_POLL_ACTIVE_STATE_BIT      = 10;
    localparam int          IS_SRQ_BIT       = 1;
    // control register bits
    localparam int          CTRL_AUTO_BIT    = 0;
    localparam int          CTRL_NEED_BIT    = 1;
    // transfer request register bits
    localparam int          XF_GO_BIT        = 0;
    localparam int          XF_DIR_BIT       = 1;
    localparam int          XF_ADDR_BIT      = 2;
    // error codes
    localparam logic [7:0]  ERR_NOT_ALLOWED  = 8'hAA;
    localparam logic [7:0]  ERR_NONE         = 8'h00;
    // reset values
    localparam logic [7:0]  RST_BYTE         = 8'h00;
    localparam logic [4:0]  RST_PP_MASK      = 5'h10;
    localparam logic [15:0] RST_INT_STATUS   = 16'h0000;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } gnc_bus_req_t;

    typedef struct packed {
        logic       atn;
        logic       eoi;
        logic       srq;
        logic [7:0] dio;
    } gnc_bus_in_t;

    typedef enum logic [1:0] {
        XF_IDLE  = 2'b00,
        XF_WAIT  = 2'b01,
        XF_RUN   = 2'b10
    } gnc_xfer_state_t;
endpackage : gnc_pkg

//--- verif/gnc_poll_responder_sva.sv
// Purpose: port-level checks of the poll responder
// Assumes: one clock, synchronous active-high reset
// Notes:   eight-cycle quiet windows cover the pin synchroniser latency
`timescale 1ns/100ps
module gnc_poll_responder_sva
    import gnc_pkg::*;
(
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              sys_rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    // bus pins
    input wire logic              bus_atn,
    input wire logic [7:0]        bus_dio_oe,
    input wire logic              bus_srq_out,
    input wire logic              bus_srq_oe,
    input wire logic              bus_addr_cmd_oe,
    // protocol state
    input wire logic              active_controller,
    input wire logic              talker_addressed,
    input wire logic              listener_addressed,
    input wire logic              serial_poll_active_state,
    input wire logic              tl_configured,
    // transfer handshake
    input wire logic              xfer_start,
    input wire logic              xfer_dir_send,
    input wire logic              xfer_send_addr
);
    logic wr_sp;
    logic wr_go;
    assign wr_sp = reg_wr && reg_addr[5:2] == IDX_SPOLL_BYTE;
    // go without the address request
    assign wr_go = reg_wr && reg_addr[5:2] == IDX_XFER && reg_wdata[XF_GO_BIT] && !reg_wdata[XF_ADDR_BIT];

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_srq_set_rsv: assert property (wr_sp && reg_wdata[SPB_RSV_BIT] |=> bus_srq_oe)
        else $error("service request not raised");
    a_srq_clr_wr: assert property (wr_sp && !reg_wdata[SPB_RSV_BIT] |=> !bus_srq_oe)
        else $error("service request not withdrawn");
    a_srq_hold_lvl: assert property (bus_srq_oe && !wr_sp && !serial_poll_active_state
        && !$past(serial_poll_active_state) |=> bus_srq_oe) else $error("service request dropped");
    a_srq_wired_or: assert property ($rose(bus_srq_oe) |-> bus_srq_out && $past(wr_sp)
        && $past(reg_wdata[SPB_RSV_BIT])) else $error("service request raised without a write");
    a_no_addr_nac: assert property (!active_controller && !$past(active_controller) |-> !bus_addr_cmd_oe)
        else $error("addressing driven while not controller");
    a_addr_cmd_gate: assert property (bus_addr_cmd_oe
        |-> active_controller && xfer_start && xfer_send_addr) else $error("addressing outside a controller transfer");
    a_stall_role: assert property ($rose(xfer_start) && !active_controller
        |-> (xfer_dir_send ? $past(talker_addressed) : $past(listener_addressed))) else $error("ran unaddressed");
    a_refuse_unset: assert property (wr_go && active_controller && !tl_configured |=> !xfer_start [*4])
        else $error("transfer ran without setup");
    a_reuse_setup: assert property (wr_go && active_controller && tl_configured
        |-> ##[1:3] xfer_start && !xfer_send_addr && !bus_addr_cmd_oe) else $error("setup not reused");
    a_pp_release: assert property ((!bus_atn && !serial_poll_active_state) [*8] |-> bus_dio_oe == 8'h00)
        else $error("data lines held after identify");
    a_ctl_no_ppoll: assert property ((active_controller && !serial_poll_active_state) [*8]
        |-> bus_dio_oe == 8'h00) else $error("data lines driven as controller");
endmodule : gnc_poll_responder_sva

bind gnc_poll_responder gnc_poll_responder_sva u_gnc_poll_responder_sva (.*);

//--- verif/gnc_ctl_model.sv
// Purpose: behavioural active controller on the far side of the bus
// Assumes: driven from the bench clock, changes right after rising edges
// Notes:   released data lines read false, as with bus pull-ups
`timescale 1ns/100ps
module gnc_ctl_model (
    // clock
    input  wire logic       ref_clk,
    // responder drive
    input  wire logic [7:0] bus_dio_oe,
    input  wire logic [7:0] bus_dio_out,
    // controller drive
    output logic            bus_atn,
    output logic            bus_eoi,
    output logic            serial_poll_active_state,
    output logic            talker_addressed,
    output logic            listener_addressed,
    output logic            ppc_received,
    output logic [7:0]      bus_dio_in
);
    logic [7:0] ctl_dio;
    logic       ctl_oe;
    // wired lines: any driver pulls a line true
    assign bus_dio_in = (ctl_oe ? ctl_dio : 8'h00) | (bus_dio_oe & bus_dio_out);
    initial begin
        {bus_atn, bus_eoi, serial_poll_active_state, talker_addressed} = 4'h0;
        {listener_addressed, ppc_received, ctl_oe} = 3'h0;
        ctl_dio = 8'h00;
    end
    task identify(input logic on);
        @(posedge ref_clk);
        bus_atn <= on;
        bus_eoi <= on;
    endtask : identify
    // configure command, enable byte left on the lines until released
    task send_cfg(input logic [7:0] cfg);
        @(posedge ref_clk);
        ctl_oe       <= 1'b1;
        ctl_dio      <= cfg;
        ppc_received <= 1'b1;
        @(posedge ref_clk);
        ppc_received <= 1'b0;
    endtask : send_cfg
    task release_dio;
        @(posedge ref_clk);
        ctl_oe <= 1'b0;
    endtask : release_dio
    task address(input logic talk, input logic lstn);
        @(posedge ref_clk);
        talker_addressed   <= talk;
        listener_addressed <= lstn;
    endtask : address
    // a serial poll addresses the device to talk
    task poll(input logic on);
        @(posedge ref_clk);
        serial_poll_active_state <= on;
        talker_addressed         <= on;
    endtask : poll
endmodule : gnc_ctl_model

//--- verif/tb_gnc_poll_responder.sv
// Purpose: self-checking bench of the poll responder
// Assumes: register port strobes one cycle, read data the cycle after
// Notes:   bus levels are judged on the wired data lines
`timescale 1ns/100ps
module tb_gnc_poll_responder
    import gnc_pkg::*;
;
    logic ref_clk, sys_rst, reg_wr, reg_rd, bus_atn, bus_eoi, bus_srq_in, bus_srq_out, bus_srq_oe;
    logic bus_addr_cmd_oe, active_controller, talker_addressed, listener_addressed, serial_poll_active_state;
    logic ppc_received, tl_configured, xfer_done, xfer_start, xfer_dir_send, xfer_send_addr, other_srq;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [7:0]        bus_dio_in, bus_dio_out, bus_dio_oe;
    int                fails, cmp_count;
    // {need, configure byte}; upper configure bits must be ignored
    localparam logic [8:0] PP_TBL [5] = '{9'h1EC, 9'h107, 9'h018, 9'h000, 9'h00B};

    // a second device may pull the request line too
    assign bus_srq_in = (bus_srq_oe & bus_srq_out) | other_srq;
    gnc_poll_responder u_gnc_poll_responder (.*);
    gnc_ctl_model u_gnc_ctl_model (.*);

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task ticks(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : ticks
    task wr(input logic [3:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= {idx, 2'b00};
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] idx, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= {idx, 2'b00};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task done_pulse;
        @(posedge ref_clk);
        xfer_done <= 1'b1;
        @(posedge ref_clk);
        xfer_done <= 1'b0;
        ticks(1);
        chk("xfer_end", 0, xfer_start);
    endtask : done_pulse

    task t_spoll;
        logic [31:0] d;
        wr(IDX_SPOLL_BYTE, 32'hC3);
        ticks(0);
        chk("srq_set", 1, bus_srq_oe);
        rd(IDX_SPOLL_BYTE, d);
        chk("spoll_byte", 32'hC3, d);
        u_gnc_ctl_model.poll(1'b1);
        ticks(8);
        chk("poll_byte", 8'hC3, bus_dio_in);
        u_gnc_ctl_model.poll(1'b0);
        ticks(3);
        chk("srq_polled", 0, bus_srq_oe);
        rd(IDX_INT_STATUS, d);
        chk("poll_event", 1, d[IS_SERIAL_POLL_ACTIVE_STATE_BIT]);
        rd(IDX_INT_STATUS, d);
        chk("int_cleared", 0, d[15:0]);
        wr(IDX_SPOLL_BYTE, 32'h40);
        ticks(0);
        chk("srq_again", 1, bus_srq_oe);
        wr(IDX_SPOLL_BYTE, 32'h03);
        ticks(0);
        chk("srq_withdrawn", 0, bus_srq_oe);
        rd(4'h3, d);
        chk("unmapped", 0, d);
        @(posedge ref_clk);
        other_srq <= 1'b1;
        ticks(8);
        rd(IDX_INT_STATUS, d);
        chk("srq_live", 32'h2, d);
        @(posedge ref_clk);
        other_srq <= 1'b0;
        ticks(8);
        rd(IDX_INT_STATUS, d);
        chk("srq_gone", 0, d);
        $display("serial poll test done");
    endtask : t_spoll

    task t_ppoll_auto;
        logic [31:0] d;
        logic [7:0]  cfg;
        logic [7:0]  line;
        u_gnc_ctl_model.send_cfg(8'hEC);
        ticks(8);
        rd(IDX_CFG_BYTE, d);
        chk("cfg_byte", 8'hEC, d[7:0]);
        rd(IDX_INT_STATUS, d);
        chk("cfg_event", 1, d[IS_PPC_BIT]);
        u_gnc_ctl_model.release_dio();
        for (int i = 0; i < 5; i++) begin
            cfg  = PP_TBL[i][7:0];
            line = cfg[4] ? 8'h00 : 8'h01 << cfg[2:0];
            wr(IDX_PP_MASK, {24'h0, cfg});
            wr(IDX_CTRL, {30'h0, PP_TBL[i][8], 1'b1});
            u_gnc_ctl_model.identify(1'b1);
            ticks(8);
            chk("pp_oe", line, bus_dio_oe);
            chk("pp_level", (PP_TBL[i][8] == cfg[3]) ? line : 8'h00, bus_dio_in);
            u_gnc_ctl_model.identify(1'b0);
            ticks(7);
            chk("pp_release", 0, bus_dio_oe);
        end
        $display("automatic parallel poll test done");
    endtask : t_ppoll_auto

    task t_ppoll_man;
        wr(IDX_CTRL, 32'h0);
        wr(IDX_PP_PATTERN, 32'h16);
        u_gnc_ctl_model.identify(1'b1);
        ticks(8);
        chk("man_level", 8'h16, bus_dio_in);
        u_gnc_ctl_model.identify(1'b0);
        ticks(7);
        chk("man_release", 0, bus_dio_oe);
        $display("manual parallel poll test done");
    endtask : t_ppoll_man

    task t_xfer;
        logic [31:0] d;
        wr(IDX_XFER, 32'h7);
        u_gnc_ctl_model.address(1'b0, 1'b1);
        ticks(6);
        chk("wrong_role", 0, xfer_start);
        u_gnc_ctl_model.address(1'b1, 1'b0);
        for (int n = 0; n < 20 && xfer_start !== 1'b1; n++) ticks(1);
        chk("send_run", 1, xfer_start);
        chk("send_dir", 1, xfer_dir_send);
        chk("no_addr", 0, bus_addr_cmd_oe);
        chk("nac_noaddr", 0, xfer_send_addr);
        done_pulse();
        wr(IDX_XFER, 32'h1);
        ticks(6);
        chk("rx_wait", 0, xfer_start);
        u_gnc_ctl_model.address(1'b0, 1'b1);
        ticks(3);
        chk("rx_run", 1, xfer_start);
        chk("rx_dir", 0, xfer_dir_send);
        done_pulse();
        u_gnc_ctl_model.address(1'b0, 1'b0);
        @(posedge ref_clk);
        active_controller <= 1'b1;
        wr(IDX_XFER, 32'h1);
        ticks(3);
        chk("refused", 0, xfer_start);
        rd(IDX_XFER_STAT, d);
        chk("err_code", ERR_NOT_ALLOWED, d[7:0]);
        @(posedge ref_clk);
        tl_configured <= 1'b1;
        wr(IDX_XFER, 32'h3);
        ticks(2);
        chk("reuse_run", 1, xfer_start);
        chk("reuse_noaddr", 0, xfer_send_addr);
        done_pulse();
        wr(IDX_XFER, 32'h5);
        ticks(2);
        chk("ctl_addr", 1, xfer_send_addr);
        chk("ctl_addr_oe", 1, bus_addr_cmd_oe);
        done_pulse();
        @(posedge ref_clk);
        active_controller <= 1'b0;
        tl_configured     <= 1'b0;
        $display("transfer test done");
    endtask : t_xfer

    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 40'h0};
        {active_controller, tl_configured, xfer_done, other_srq} = 4'h0;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_spoll();
        t_ppoll_auto();
        t_ppoll_man();
        t_xfer();
        finish_test();
    end
    // whole run is a few hundred cycles
    initial begin
        #100000;
        fails++;
        finish_test();
    end
endmodule : tb_gnc_poll_responder
